// >>> design/serial_pkg.sv
/*
 * Shared constants and types for the serial character engine: register
 * offsets, field positions, reset values, frame lengths and state codes.
 * Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
 */
package serial_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL_ONE = 8'h00; // serial_control_one
	localparam logic [7:0] OFF_CTRL_TWO = 8'h04; // serial_control_two
	localparam logic [7:0] OFF_CTRL_THREE = 8'h08; // serial_control_three
	localparam logic [7:0] OFF_STAT_ONE = 8'h0c; // serial_status_one
	localparam logic [7:0] OFF_STAT_TWO = 8'h10; // serial_status_two
	localparam logic [7:0] OFF_DATA = 8'h14; // serial_data_buffer
	localparam logic [7:0] OFF_BAUD = 8'h18; // baud_select_register
	localparam logic [7:0] OFF_CONFIG = 8'h1c; // system_config_two

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int C1_MODULE_EN = 0;
	localparam int C1_CHAR9 = 1;
	localparam int C1_INVERT = 2;
	localparam int C2_TX_EN = 0;
	localparam int C2_RX_EN = 1;
	localparam int C2_SEND_BREAK = 2;
	localparam int C2_TBE_IE = 3;
	localparam int C2_TC_IE = 4;
	localparam int C2_RXF_IE = 5;
	localparam int C3_TX_NINTH = 0;
	localparam int C3_RX_NINTH = 1;
	localparam int S1_TBE = 0;
	localparam int S1_TC = 1;
	localparam int S1_RXF = 2;
	localparam int S1_FE = 3;
	localparam int S1_NF = 4;
	localparam int S2_BREAK = 0;
	localparam int S2_RX_BUSY = 1;
	localparam int BAUD_LONG_BREAK = 8;
	localparam int CFG_BUS_SRC = 0;

	// ----------------------------------------------------------------
	// reset values and timing counts
	// ----------------------------------------------------------------
	localparam logic [7:0] DIVISOR_RESET = 8'h00;
	localparam logic CFG_BUS_SRC_RESET = 1'b1;
	// bus clock is a quarter of the fast oscillator clock (aclk)
	localparam logic [1:0] BUS_PRESCALE_LAST = 2'h3;
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hf; // 16 ticks per bit
	localparam logic [3:0] FRAME_LEN_8 = 4'ha;
	localparam logic [3:0] FRAME_LEN_9 = 4'hb;
	localparam logic [3:0] DATA_LEN_8 = 4'h8;
	localparam logic [3:0] DATA_LEN_9 = 4'h9;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic baud_clock_source_sel;
		logic long_break_sel;
		logic [7:0] divisor;
		logic rx_full_irq_en;
		logic tx_complete_irq_en;
		logic tx_empty_irq_en;
		logic send_break;
		logic rx_enable;
		logic tx_enable;
		logic tx_invert;
		logic char9;
		logic module_enable;
		logic tx_ninth_bit;
	} ctrl_s;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_IDLECHAR = 3'h1,
		TX_DATA = 3'h3,
		TX_BREAK = 3'h2,
		TX_MARK = 3'h6
	} tx_state_e;

	typedef enum logic [1:0] {
		RX_IDLE = 2'h0,
		RX_START = 2'h1,
		RX_BITS = 2'h3,
		RX_EXTRA = 2'h2
	} rx_state_e;

endpackage

// >>> design/baud_tick_gen.sv
/*
 * Shared baud generator: one-cycle oversample tick at 16x the baud rate.
 * Assumes aclk is the fast oscillator clock; the bus-clock source is
 * modelled as a divide-by-four enable of aclk.
 */
`timescale 1ns/1ns
`default_nettype none

module baud_tick_gen (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// configuration
	input wire logic run,
	input wire logic bus_src,
	input wire logic [7:0] divisor,
	// tick out
	output logic oversample_tick
);

	logic [1:0] pre_ff;
	logic [7:0] cnt_ff;
	logic src_en;

	assign src_en = !bus_src || (pre_ff == serial_pkg::BUS_PRESCALE_LAST); // R21

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			pre_ff <= 2'h0;
		end else begin
			pre_ff <= pre_ff + 2'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_ff <= 8'h00;
			oversample_tick <= 1'b0;
		end else begin
			oversample_tick <= 1'b0;
			if (src_en) begin
				if (cnt_ff >= divisor) begin
					cnt_ff <= 8'h00;
					oversample_tick <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + 8'h01;
				end
			end
		end
	end

endmodule
`default_nettype wire

// >>> design/async_serial_char_engine.sv
/*
 * Full-duplex asynchronous serial transmitter and receiver with an
 * AXI4-Lite register slave. Assumes one 250 MHz clock, synchronous
 * active-low reset and a receive input already synchronous to aclk.
 */
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// R01: transmit 8 or 9 bit characters; ninth bit comes from tx_ninth_bit
// R02: rx_ninth_bit holds received bit 8, or a copy of bit 7 in 8-bit mode
// R03: each transmission starts with an all-ones preamble before data is loaded; code sends none when tx_enable is cleared and set again while idle
// R04: frames carry a 0 start bit first and a 1 stop bit last
// R05: tx_buffer_empty sets when the buffer hands a byte to the shifter
// R06: tx_buffer_empty clears only by status-one read then data write
// R07: software enables module, then transmitter, then writes data
// R08: the line rests at logic 1 when nothing is shifted
// R09: clearing module_enable releases both pins at once
// R10: break is all zeros, length from char length and long break select
// R11: breaks repeat while send_break is set, then at least one 1 bit
// R12: break detected on 10/11 zeros, or 11/12 with long break select
// R13: break sets framing, full and break flags, clears data and ninth bit
// R14: idle character is all ones of character length; preamble is one
// R15: clearing tx_enable mid-character finishes it, then the line idles
// R16: clearing and resetting tx_enable mid-character queues one idle character
// R17: tx_invert inverts every transmitted level
// R18: tx_complete sets when shifter and buffer are empty and nothing generated
// R19: received data goes to the buffer and sets rx_full with its interrupt
// R20: data address writes the transmit buffer and reads the receive buffer
// R21: transmitter and receiver share one baud generator with selectable source
// R22: the receiver samples at 16 times the baud rate
// R23: framing error set with rx_full when the stop position holds no 1
// R24: data bits go out least significant first, ninth bit last
module async_serial_char_engine (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial line
	input wire logic rxd,
	output logic txd_out,
	output logic txd_oe,
	// interrupt requests
	output logic tx_irq,
	output logic rx_irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	serial_pkg::ctrl_s ctrl_ff;
	serial_pkg::tx_state_e tx_state_ff;
	serial_pkg::rx_state_e rx_state_ff;
	logic [7:0] tx_buf_ff, rx_buf_ff;
	logic tbe_ff, tc_ff, rxf_ff, fe_ff, nf_ff, brk_ff, rx_ninth_ff, armed_ff;
	logic [10:0] tx_sh_ff;
	logic [3:0] tx_cnt_ff, tx_rt_ff, rx_rt_ff, rx_idx_ff;
	logic need_pre_ff, queue_idle_ff, te_prev_ff;
	logic [8:0] rx_sh_ff;
	logic [2:0] rx_hist_ff;
	logic [1:0] rx_smp_ff;
	logic rx_noise_ff, rx_zero_ff;
	logic os_tick;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr[7:2] == off[7:2]);
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr[7:2] <= serial_pkg::OFF_CONFIG[7:2]);
	endfunction

	function automatic logic vote(input logic [2:0] s);
		vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic wr_do, rd_do, en;
	logic [31:0] rd_val;
	assign wr_do = s_axi_awready && s_axi_wready;
	assign rd_do = s_axi_arready;
	assign en = ctrl_ff.module_enable;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= serial_pkg::RESP_OKAY;
		end else begin
			// both channels are taken together, one write at a time
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(s_axi_awaddr) ? serial_pkg::RESP_OKAY
					: serial_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_val = 32'h0;
		if (hit(s_axi_araddr, serial_pkg::OFF_CTRL_ONE)) begin
			rd_val[serial_pkg::C1_MODULE_EN] = ctrl_ff.module_enable;
			rd_val[serial_pkg::C1_CHAR9] = ctrl_ff.char9;
			rd_val[serial_pkg::C1_INVERT] = ctrl_ff.tx_invert;
		end else if (hit(s_axi_araddr, serial_pkg::OFF_CTRL_TWO)) begin
			rd_val[serial_pkg::C2_TX_EN] = ctrl_ff.tx_enable;
			rd_val[serial_pkg::C2_RX_EN] = ctrl_ff.rx_enable;
			rd_val[serial_pkg::C2_SEND_BREAK] = ctrl_ff.send_break;
			rd_val[serial_pkg::C2_TBE_IE] = ctrl_ff.tx_empty_irq_en;
			rd_val[serial_pkg::C2_TC_IE] = ctrl_ff.tx_complete_irq_en;
			rd_val[serial_pkg::C2_RXF_IE] = ctrl_ff.rx_full_irq_en;
		end else if (hit(s_axi_araddr, serial_pkg::OFF_CTRL_THREE)) begin
			rd_val[serial_pkg::C3_TX_NINTH] = ctrl_ff.tx_ninth_bit;
			rd_val[serial_pkg::C3_RX_NINTH] = rx_ninth_ff;
		end else if (hit(s_axi_araddr, serial_pkg::OFF_STAT_ONE)) begin
			rd_val[serial_pkg::S1_TBE] = tbe_ff;
			rd_val[serial_pkg::S1_TC] = tc_ff;
			rd_val[serial_pkg::S1_RXF] = rxf_ff;
			rd_val[serial_pkg::S1_FE] = fe_ff;
			rd_val[serial_pkg::S1_NF] = nf_ff;
		end else if (hit(s_axi_araddr, serial_pkg::OFF_STAT_TWO)) begin
			rd_val[serial_pkg::S2_BREAK] = brk_ff;
			rd_val[serial_pkg::S2_RX_BUSY] = (rx_state_ff != serial_pkg::RX_IDLE);
		end else if (hit(s_axi_araddr, serial_pkg::OFF_DATA)) begin
			rd_val[7:0] = rx_buf_ff; // R20
		end else if (hit(s_axi_araddr, serial_pkg::OFF_BAUD)) begin
			rd_val[7:0] = ctrl_ff.divisor;
			rd_val[serial_pkg::BAUD_LONG_BREAK] = ctrl_ff.long_break_sel;
		end else if (hit(s_axi_araddr, serial_pkg::OFF_CONFIG)) begin
			rd_val[serial_pkg::CFG_BUS_SRC] = ctrl_ff.baud_clock_source_sel;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= serial_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (rd_do) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= mapped(s_axi_araddr) ? serial_pkg::RESP_OKAY
					: serial_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	logic wlo, whi;
	assign wlo = wr_do && s_axi_wstrb[0];
	assign whi = wr_do && s_axi_wstrb[1];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= '0;
			ctrl_ff.divisor <= serial_pkg::DIVISOR_RESET;
			ctrl_ff.baud_clock_source_sel <= serial_pkg::CFG_BUS_SRC_RESET;
		end else begin
			if (wlo && hit(s_axi_awaddr, serial_pkg::OFF_CTRL_ONE)) begin
				ctrl_ff.module_enable <= s_axi_wdata[serial_pkg::C1_MODULE_EN];
				ctrl_ff.char9 <= s_axi_wdata[serial_pkg::C1_CHAR9];
				ctrl_ff.tx_invert <= s_axi_wdata[serial_pkg::C1_INVERT];
			end
			if (wlo && hit(s_axi_awaddr, serial_pkg::OFF_CTRL_TWO)) begin
				ctrl_ff.tx_enable <= s_axi_wdata[serial_pkg::C2_TX_EN];
				ctrl_ff.rx_enable <= s_axi_wdata[serial_pkg::C2_RX_EN];
				ctrl_ff.send_break <= s_axi_wdata[serial_pkg::C2_SEND_BREAK];
				ctrl_ff.tx_empty_irq_en <= s_axi_wdata[serial_pkg::C2_TBE_IE];
				ctrl_ff.tx_complete_irq_en <= s_axi_wdata[serial_pkg::C2_TC_IE];
				ctrl_ff.rx_full_irq_en <= s_axi_wdata[serial_pkg::C2_RXF_IE];
			end
			if (wlo && hit(s_axi_awaddr, serial_pkg::OFF_CTRL_THREE)) begin
				ctrl_ff.tx_ninth_bit <= s_axi_wdata[serial_pkg::C3_TX_NINTH];
			end
			if (wlo && hit(s_axi_awaddr, serial_pkg::OFF_BAUD)) begin
				ctrl_ff.divisor <= s_axi_wdata[7:0];
			end
			if (whi && hit(s_axi_awaddr, serial_pkg::OFF_BAUD)) begin
				ctrl_ff.long_break_sel <= s_axi_wdata[serial_pkg::BAUD_LONG_BREAK];
			end
			if (wlo && hit(s_axi_awaddr, serial_pkg::OFF_CONFIG)) begin
				ctrl_ff.baud_clock_source_sel <= s_axi_wdata[serial_pkg::CFG_BUS_SRC];
			end
		end
	end

	baud_tick_gen u_baud (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(en),
		.bus_src(ctrl_ff.baud_clock_source_sel),
		.divisor(ctrl_ff.divisor),
		.oversample_tick(os_tick)
	); // R21

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	logic tx_en, char_end, pick, take;
	logic [3:0] frame_len;
	assign tx_en = en && ctrl_ff.tx_enable;
	assign frame_len = ctrl_ff.char9 ? serial_pkg::FRAME_LEN_9 : serial_pkg::FRAME_LEN_8;
	assign char_end = (tx_state_ff != serial_pkg::TX_IDLE) && os_tick
		&& (tx_rt_ff == serial_pkg::OVERSAMPLE_LAST) && (tx_cnt_ff == 4'h1);
	assign pick = ((tx_state_ff == serial_pkg::TX_IDLE) && tx_en) || char_end;
	assign take = pick && tx_en && !need_pre_ff && !queue_idle_ff && !ctrl_ff.send_break
		&& (tx_state_ff != serial_pkg::TX_BREAK) && !tbe_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn || !en) begin
			tx_state_ff <= serial_pkg::TX_IDLE;
			tx_sh_ff <= '1;
			tx_cnt_ff <= 4'h0;
			tx_rt_ff <= 4'h0;
			need_pre_ff <= 1'b1;
			queue_idle_ff <= 1'b0;
			te_prev_ff <= 1'b0;
		end else begin
			te_prev_ff <= ctrl_ff.tx_enable;
			if (ctrl_ff.tx_enable && !te_prev_ff && tx_state_ff != serial_pkg::TX_IDLE) begin
				queue_idle_ff <= 1'b1; // R16
			end
			if (os_tick && tx_state_ff != serial_pkg::TX_IDLE) begin
				tx_rt_ff <= tx_rt_ff + 4'h1;
			end
			if (pick) begin
				tx_rt_ff <= 4'h0;
				if (!tx_en) begin
					tx_state_ff <= serial_pkg::TX_IDLE; // R15
					need_pre_ff <= 1'b1;
				end else if (need_pre_ff || queue_idle_ff) begin
					tx_state_ff <= serial_pkg::TX_IDLECHAR; // R03 R14
					tx_sh_ff <= '1;
					tx_cnt_ff <= frame_len;
					need_pre_ff <= 1'b0;
					queue_idle_ff <= 1'b0;
				end else if (ctrl_ff.send_break) begin
					tx_state_ff <= serial_pkg::TX_BREAK; // R10 R11
					tx_sh_ff <= '0;
					tx_cnt_ff <= frame_len + {3'h0, ctrl_ff.long_break_sel};
				end else if (tx_state_ff == serial_pkg::TX_BREAK) begin
					tx_state_ff <= serial_pkg::TX_MARK; // R11
					tx_sh_ff <= '1;
					tx_cnt_ff <= 4'h1;
				end else if (take) begin
					tx_state_ff <= serial_pkg::TX_DATA;
					// lsb first after the start bit, ninth bit just before stop
					tx_sh_ff <= {1'b1, ctrl_ff.char9 ? ctrl_ff.tx_ninth_bit : 1'b1,
						tx_buf_ff, 1'b0}; // R01 R04 R24
					tx_cnt_ff <= frame_len;
				end else begin
					tx_state_ff <= serial_pkg::TX_IDLE;
				end
			end else if (os_tick && tx_state_ff != serial_pkg::TX_IDLE
				&& tx_rt_ff == serial_pkg::OVERSAMPLE_LAST) begin
				tx_sh_ff <= {tx_state_ff != serial_pkg::TX_BREAK, tx_sh_ff[10:1]}; // R10
				tx_cnt_ff <= tx_cnt_ff - 4'h1;
			end
		end
	end

	// tx buffer flags; the hand-over set wins over a same-cycle clear
	logic data_wr, data_rd;
	assign data_wr = wlo && hit(s_axi_awaddr, serial_pkg::OFF_DATA);
	assign data_rd = rd_do && hit(s_axi_araddr, serial_pkg::OFF_DATA);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tbe_ff <= 1'b1;
			tx_buf_ff <= 8'h00;
			armed_ff <= 1'b0;
			tc_ff <= 1'b1;
		end else begin
			if (rd_do && hit(s_axi_araddr, serial_pkg::OFF_STAT_ONE)) begin
				armed_ff <= 1'b1;
			end else if (data_wr || data_rd) begin
				armed_ff <= 1'b0;
			end
			if (data_wr) begin
				tx_buf_ff <= s_axi_wdata[7:0]; // R20
			end
			if (take) begin
				tbe_ff <= 1'b1; // R05
			end else if (data_wr && armed_ff) begin
				tbe_ff <= 1'b0; // R06
			end
			tc_ff <= (tx_state_ff == serial_pkg::TX_IDLE) && tbe_ff && !take
				&& !(tx_en && (need_pre_ff || ctrl_ff.send_break)); // R18
		end
	end

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	logic [3:0] data_len;
	logic smp_bit, rx_done, rx_fe, rx_brk;
	assign data_len = ctrl_ff.char9 ? serial_pkg::DATA_LEN_9 : serial_pkg::DATA_LEN_8;
	assign smp_bit = vote({rx_smp_ff, rxd});

	always_ff @(posedge aclk) begin
		if (!aresetn || !en || !ctrl_ff.rx_enable) begin
			rx_state_ff <= serial_pkg::RX_IDLE;
			rx_rt_ff <= 4'h0;
			rx_idx_ff <= 4'h0;
			rx_hist_ff <= 3'h0;
			rx_smp_ff <= 2'h0;
			rx_sh_ff <= 9'h0;
			rx_noise_ff <= 1'b0;
			rx_zero_ff <= 1'b0;
			rx_done <= 1'b0;
			rx_fe <= 1'b0;
			rx_brk <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			rx_fe <= 1'b0;
			rx_brk <= 1'b0;
			if (os_tick) begin // R22
				rx_rt_ff <= rx_rt_ff + 4'h1;
				if (rx_rt_ff == 4'h2 || rx_rt_ff == 4'h4 || rx_rt_ff == 4'h7
					|| rx_rt_ff == 4'h8) begin
					rx_smp_ff <= {rx_smp_ff[0], rxd};
				end
				case (rx_state_ff)
					serial_pkg::RX_IDLE: begin
						rx_hist_ff <= {rx_hist_ff[1:0], rxd};
						if (!rxd && rx_hist_ff == 3'h7) begin
							rx_state_ff <= serial_pkg::RX_START;
							rx_rt_ff <= 4'h0;
							rx_noise_ff <= 1'b0;
						end
					end
					serial_pkg::RX_START: begin
						if (rx_rt_ff == 4'h6) begin
							if (smp_bit) begin
								rx_state_ff <= serial_pkg::RX_IDLE;
							end else begin
								rx_noise_ff <= |{rx_smp_ff, rxd};
							end
						end
						if (rx_rt_ff == serial_pkg::OVERSAMPLE_LAST) begin
							rx_state_ff <= serial_pkg::RX_BITS;
							rx_idx_ff <= 4'h0;
							rx_zero_ff <= 1'b1;
						end
					end
					serial_pkg::RX_BITS, serial_pkg::RX_EXTRA: begin
						if (rx_rt_ff == 4'h9) begin
							if ({rx_smp_ff, rxd} != 3'h0 && {rx_smp_ff, rxd} != 3'h7) begin
								rx_noise_ff <= 1'b1;
							end
							rx_idx_ff <= rx_idx_ff + 4'h1;
							if (rx_state_ff == serial_pkg::RX_EXTRA) begin
								rx_state_ff <= serial_pkg::RX_IDLE;
								rx_done <= 1'b1;
								rx_fe <= 1'b1;
								rx_brk <= !smp_bit; // R12
							end else if (rx_idx_ff < data_len) begin
								rx_sh_ff <= {smp_bit, rx_sh_ff[8:1]};
								rx_zero_ff <= rx_zero_ff && !smp_bit;
							end else if (!smp_bit && rx_zero_ff
								&& ctrl_ff.long_break_sel) begin
								rx_state_ff <= serial_pkg::RX_EXTRA; // R12
							end else begin
								rx_state_ff <= serial_pkg::RX_IDLE;
								rx_done <= 1'b1;
								rx_fe <= !smp_bit; // R23
								rx_brk <= !smp_bit && rx_zero_ff; // R12
							end
						end
					end
					default: begin
						rx_state_ff <= serial_pkg::RX_IDLE;
					end
				endcase
			end
			// a break leaves the line low, so fresh ones are needed first
			if (rx_done) begin
				rx_hist_ff <= 3'h0;
			end
		end
	end

	// receive buffer and flags; a new character wins over a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_buf_ff <= 8'h00;
			rx_ninth_ff <= 1'b0;
			rxf_ff <= 1'b0;
			fe_ff <= 1'b0;
			nf_ff <= 1'b0;
			brk_ff <= 1'b0;
		end else if (rx_done) begin
			rxf_ff <= 1'b1; // R19
			fe_ff <= rx_fe; // R23
			nf_ff <= rx_noise_ff;
			if (rx_brk) begin
				rx_buf_ff <= 8'h00; // R13
				rx_ninth_ff <= 1'b0;
				brk_ff <= 1'b1;
			end else begin
				rx_buf_ff <= ctrl_ff.char9 ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
				rx_ninth_ff <= rx_sh_ff[8]; // R02
			end
		end else if (data_rd && armed_ff) begin
			rxf_ff <= 1'b0;
			fe_ff <= 1'b0;
			nf_ff <= 1'b0;
			brk_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// pins and requests
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txd_out <= 1'b1;
			txd_oe <= 1'b0;
			tx_irq <= 1'b0;
			rx_irq <= 1'b0;
		end else begin
			txd_out <= ((tx_state_ff == serial_pkg::TX_IDLE) ? 1'b1 : tx_sh_ff[0]) // R08
				^ ctrl_ff.tx_invert; // R17
			txd_oe <= en && (ctrl_ff.tx_enable // R09
				|| tx_state_ff != serial_pkg::TX_IDLE); // R15
			tx_irq <= (tbe_ff && ctrl_ff.tx_empty_irq_en)
				|| (tc_ff && ctrl_ff.tx_complete_irq_en); // R05 R18
			rx_irq <= rxf_ff && ctrl_ff.rx_full_irq_en; // R19
		end
	end

endmodule
`default_nettype wire

// >>> dv/serial_partner.sv
/* remote serial device: decodes 8-bit frames from the line, sends frames on rxd.
   assumes BIT aclk cycles per bit and no output inversion. */
`timescale 1ns/1ns
`default_nettype none
module serial_partner #(parameter int BIT = 64) (
	// line
	input wire logic aclk,
	input wire logic txd,
	output logic rxd,
	// decoded character
	output logic [7:0] got,
	output logic got_stb
);
	initial begin
		rxd = 1'b1;
		got_stb = 1'b0;
	end
	// mid-bit sampling; a frame without a stop 1 never strobes
	initial forever begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge aclk);
			got[i] = txd;
		end
		repeat (BIT) @(posedge aclk);
		got_stb <= txd;
		@(posedge aclk);
		got_stb <= 1'b0;
	end
	task automatic send(input logic [10:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge aclk);
		end
		rxd <= 1'b1;
	endtask
endmodule
`default_nettype wire

// >>> dv/serial_checker_assertions.sv
/* bus handshake and line properties on the engine's ports.
   assumes one clock aclk with synchronous active-low reset aresetn. */
`timescale 1ns/1ns
`default_nettype none
module serial_checker (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// line and requests
	input wire logic txd_out,
	input wire logic txd_oe,
	input wire logic tx_irq,
	input wire logic rx_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
		else $error("write address and data accepted apart");
	chk_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
		&& !s_axi_bvalid |=> s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
	chk_read_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
		|=> s_axi_arready ##1 s_axi_rvalid) else $error("read answer late");
	chk_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid held after bready");
	chk_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid held after rready");
	chk_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == serial_pkg::RESP_SLVERR
		|-> s_axi_rdata == 32'h0) else $error("refused read returned data");
	chk_reset_idle: assert property ($rose(aresetn) |-> txd_out && !txd_oe
		&& !tx_irq && !rx_irq) else $error("line or requests not idle after reset");
	// shortest bit is 16 aclk, so a level change must hold
	chk_bit_hold: assert property (txd_oe && $stable(txd_oe) && $changed(txd_out)
		|=> $stable(txd_out)[*8]) else $error("line level shorter than a bit");
endmodule
bind async_serial_char_engine serial_checker u_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .txd_out, .txd_oe, .tx_irq, .rx_irq);
`default_nettype wire

// >>> dv/tb.sv
/* self-checking bench: register bus master, remote serial partner, byte scoreboard.
   assumes default baud source, divisor 0: 64 aclk per bit. */
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, txd_out, txd_oe, tx_irq, rx_irq, rxd, got_stb;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, got, b;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [7:0] exp_q[$];
	int failures = 0, cmp_count = 0;
	wire line = txd_oe ? txd_out : 1'b1; // pulled up when released
	always #2 aclk = ~aclk;
	async_serial_char_engine DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.rxd, .txd_out, .txd_oe, .tx_irq, .rx_irq);
	serial_partner P (.aclk, .txd(line), .rxd, .got, .got_stb);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic conclude;
		$display("failures %0d comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk("bresp", {30'h0, serial_pkg::RESP_OKAY}, {30'h0, s_axi_bresp});
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic poll(input int n);
		do rd(serial_pkg::OFF_STAT_ONE); while (d[n] !== 1'b1);
	endtask
	always @(posedge aclk) if (got_stb === 1'b1) chk("tx byte", {24'h0, exp_q.pop_front()}, {24'h0, got});
	initial begin
		void'($urandom(991));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(serial_pkg::OFF_STAT_ONE);
		chk("status one", 32'h3, d);
		rd(serial_pkg::OFF_CONFIG);
		chk("config", 32'h1, d);
		rd(8'h20);
		chk("unmapped resp", {30'h0, serial_pkg::RESP_SLVERR}, {30'h0, r});
		wr(serial_pkg::OFF_CTRL_ONE, 32'h1);
		wr(serial_pkg::OFF_CTRL_TWO, 32'h2b);
		repeat (2) @(posedge aclk);
		chk("tx irq", 32'h1, {31'h0, tx_irq});
		chk("line enable", 32'h1, {31'h0, txd_oe});
		repeat (2) begin
			poll(serial_pkg::S1_TBE);
			b = 8'($urandom);
			exp_q.push_back(b);
			wr(serial_pkg::OFF_DATA, {24'h0, b});
		end
		poll(serial_pkg::S1_TC);
		chk("bytes left", 32'h0, exp_q.size());
		b = 8'($urandom);
		P.send({1'b1, b, 1'b0}, 10);
		poll(serial_pkg::S1_RXF);
		chk("rx irq", 32'h1, {31'h0, rx_irq});
		rd(serial_pkg::OFF_CTRL_THREE);
		chk("rx ninth", {31'h0, b[7]}, {31'h0, d[serial_pkg::C3_RX_NINTH]});
		rd(serial_pkg::OFF_DATA);
		chk("rx data", {24'h0, b}, d);
		P.send(11'h0, 11);
		poll(serial_pkg::S1_RXF);
		chk("fe and full", 32'h3, {30'h0, d[3:2]});
		rd(serial_pkg::OFF_STAT_TWO);
		chk("break flag", 32'h1, {31'h0, d[serial_pkg::S2_BREAK]});
		rd(serial_pkg::OFF_DATA);
		chk("break data", 32'h0, d);
		wr(serial_pkg::OFF_CTRL_ONE, 32'h0);
		repeat (2) @(posedge aclk);
		chk("line release", 32'h0, {31'h0, txd_oe});
		conclude;
	end
	initial begin
		#200000;
		failures++;
		conclude;
	end
endmodule
`default_nettype wire
